// *** logic/ars_defs.svh ***
`ifndef ARS_DEFS_SVH
`define ARS_DEFS_SVH
// Bus voltage code is in whole volts
`define ARS_VW              10
`define ARS_V_DOUBLER       10'd200
`define ARS_V_BYPASS        10'd235
`define ARS_V_BUSGOOD_OFF   10'd205
`define ARS_V_RUN_OFF       10'd200
`define ARS_V_OVERVOLT      10'd400
`define ARS_V_UNDERVOLT     10'd180
`define ARS_SETTLE_DELTA    10'd2
`define ARS_SETTLE_COUNT    4
`define ARS_SAMPLE_NS       1000000
`define ARS_CLK_NS          4
`define ARS_SAMPLE_CYC      (`ARS_SAMPLE_NS / `ARS_CLK_NS)
`define ARS_DELAY_MS        50
`define ARS_DELAY_CYC       (`ARS_DELAY_MS * 1000000 / `ARS_CLK_NS)
`endif

// *** logic/ars_pkg.sv ***
package ars_pkg;
  typedef enum logic [2:0] {
    ARS_CHARGE,
    ARS_WAIT_RUN,
    ARS_WAIT_GOOD,
    ARS_RUNNING,
    ARS_DECAY,
    ARS_OVERVOLT
  } ars_state_t;
  typedef struct packed {
    logic bypass_closed;
    logic doubler_on;
    logic conv_run;
    logic bus_good_n;
  } ars_out_t;
endpackage

// *** logic/ars_seq.sv ***
// Contract
// - At power-up thermistor bypass and doubler strap switches are open.
// - At power-up converters disabled and bus-good output high (not good).
// - After settling, engage doubler if bus below 200 V, else leave off.
// - After settling, close bypass only if bus above 235 V.
// - Enable converters 50 ms after closing the bypass switch.
// - Assert bus-good 50 ms after enabling the converters.
// - While decaying, drop bus-good when bus falls below 205 V.
// - While decaying, disable converters when bus falls below 200 V.
// - Power returning after converter disable reruns the full power-up.
// - Power returning before disable threshold does not restart power-up.
// - Disable converters whenever bus exceeds 400 V.
// - On overvoltage also open the thermistor bypass switch.
// - Open the bypass switch when bus drops below 180 V.
// - Converter run output is active high.
`timescale 1ns/100ps
`include "ars_defs.svh"
module ars_seq #(
  parameter int SAMPLE_CYC  = `ARS_SAMPLE_CYC,
  parameter int DELAY_CYC   = `ARS_DELAY_CYC,
  parameter int SETTLE_CNT  = `ARS_SETTLE_COUNT
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Bus voltage measurement
  input  wire logic [`ARS_VW-1:0]  bus_volt,
  // Switch and converter controls, and per-sample strobe
  output ars_pkg::ars_out_t        ctl,
  output logic                     sample_tick
);
  import ars_pkg::*;

  logic [`ARS_VW-1:0] volt_s;
  logic [`ARS_VW-1:0] volt_q;
  logic [`ARS_VW-1:0] prev_q;
  logic [31:0]        samp_cnt_q;
  logic [31:0]        dly_cnt_q;
  logic [3:0]         settle_q;
  logic               settled;
  logic               tick;
  logic [`ARS_VW-1:0] diff;
  ars_state_t         state_q;
  ars_out_t           ctl_q;

  ars_sync #(
    .W(`ARS_VW)
  ) u_sync (
    .clk   (clk),
    .arst_n(arst_n),
    .d     (bus_volt),
    .q     (volt_s)
  );

  assign tick = (samp_cnt_q == 32'(SAMPLE_CYC - 1));

  // Sample timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      samp_cnt_q <= '0;
    end else if (tick) begin
      samp_cnt_q <= '0;
    end else begin
      samp_cnt_q <= samp_cnt_q + 32'd1;
    end
  end

  // Sample capture and comparison once per period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_q      <= '0;
      prev_q      <= '0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= tick;
      if (tick) begin
        prev_q <= volt_q;
        volt_q <= volt_s;
      end
    end
  end

  assign diff = (volt_q > prev_q) ? (volt_q - prev_q) : (prev_q - volt_q);

  // Settling detector
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_q <= '0;
    end else if (state_q != ARS_CHARGE) begin
      settle_q <= '0;
    end else if (sample_tick) begin
      if (diff < `ARS_SETTLE_DELTA) begin
        if (settle_q != 4'(SETTLE_CNT)) begin
          settle_q <= settle_q + 4'd1;
        end
      end else begin
        settle_q <= '0;
      end
    end
  end

  // Hold off in the sample cycle: volt_q is new there but not yet judged by the counter
  assign settled = (settle_q == 4'(SETTLE_CNT)) && !sample_tick;

  // Delay counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_cnt_q <= '0;
    end else if (state_q == ARS_WAIT_RUN || state_q == ARS_WAIT_GOOD) begin
      if (dly_cnt_q == 32'(DELAY_CYC - 1)) begin
        dly_cnt_q <= '0;
      end else begin
        dly_cnt_q <= dly_cnt_q + 32'd1;
      end
    end else begin
      dly_cnt_q <= '0;
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ARS_CHARGE;
      ctl_q   <= '{bypass_closed: 1'b0, doubler_on: 1'b0,
                   conv_run: 1'b0, bus_good_n: 1'b1};
    end else if (sample_tick && volt_q > `ARS_V_OVERVOLT && state_q != ARS_CHARGE) begin
      state_q             <= ARS_OVERVOLT;
      ctl_q.conv_run      <= 1'b0;
      ctl_q.bypass_closed <= 1'b0;
      ctl_q.bus_good_n    <= 1'b1;
    end else begin
      if (sample_tick && volt_q < `ARS_V_UNDERVOLT) begin
        ctl_q.bypass_closed <= 1'b0;
      end
      case (state_q)
        ARS_CHARGE: begin
          if (sample_tick && volt_q > `ARS_V_OVERVOLT) begin
            ctl_q.conv_run      <= 1'b0;
            ctl_q.bypass_closed <= 1'b0;
          end else if (settled) begin
            if (volt_q < `ARS_V_DOUBLER && !ctl_q.doubler_on) begin
              ctl_q.doubler_on <= 1'b1;
            end else if (volt_q > `ARS_V_BYPASS) begin
              ctl_q.bypass_closed <= 1'b1;
              state_q             <= ARS_WAIT_RUN;
            end
          end
        end
        ARS_WAIT_RUN: begin
          if (sample_tick && volt_q < `ARS_V_UNDERVOLT) begin
            // Bypass was reopened by the collapse: never enable into an open bypass
            state_q <= ARS_CHARGE;
          end else if (dly_cnt_q == 32'(DELAY_CYC - 1)) begin
            ctl_q.conv_run <= 1'b1;
            state_q        <= ARS_WAIT_GOOD;
          end
        end
        ARS_WAIT_GOOD: begin
          if (dly_cnt_q == 32'(DELAY_CYC - 1)) begin
            ctl_q.bus_good_n <= 1'b0;
            state_q          <= ARS_RUNNING;
          end
        end
        ARS_RUNNING: begin
          if (sample_tick && volt_q < `ARS_V_BUSGOOD_OFF) begin
            ctl_q.bus_good_n <= 1'b1;
            state_q          <= ARS_DECAY;
          end
        end
        ARS_DECAY: begin
          if (sample_tick && volt_q < `ARS_V_RUN_OFF) begin
            ctl_q.conv_run   <= 1'b0;
            ctl_q.doubler_on <= 1'b0;
            ctl_q.bypass_closed <= 1'b0;
            state_q          <= ARS_CHARGE;
          end else if (sample_tick && volt_q > `ARS_V_BYPASS) begin
            ctl_q.bus_good_n <= 1'b0;
            state_q          <= ARS_RUNNING;
          end
        end
        ARS_OVERVOLT: begin
          // Recover through a full power-up once the bus is back in range
          if (sample_tick && volt_q <= `ARS_V_OVERVOLT) begin
            ctl_q.doubler_on <= 1'b0;
            state_q          <= ARS_CHARGE;
          end
        end
        default: begin
          state_q <= ARS_CHARGE;
        end
      endcase
    end
  end

  assign ctl = ctl_q;


  property p_run_after_bypass;
    @(posedge clk) disable iff (!arst_n)
      $rose(ctl_q.conv_run) |-> state_q == ARS_WAIT_GOOD && $past(state_q) == ARS_WAIT_RUN;
  endproperty
  a_run_after_bypass: assert property (p_run_after_bypass)
    else $error("run enabled outside bypass delay");

  property p_wait_run_idle;
    @(posedge clk) disable iff (!arst_n)
      state_q == ARS_WAIT_RUN |-> !ctl_q.conv_run && ctl_q.bus_good_n;
  endproperty
  a_wait_run_idle: assert property (p_wait_run_idle)
    else $error("converters or bus good active during bypass delay");

  property p_good_after_run;
    @(posedge clk) disable iff (!arst_n)
      $fell(ctl_q.bus_good_n) |-> ctl_q.conv_run;
  endproperty
  a_good_after_run: assert property (p_good_after_run)
    else $error("bus good without converters running");

  property p_run_needs_bypass;
    @(posedge clk) disable iff (!arst_n)
      $rose(ctl_q.conv_run) |-> ctl_q.bypass_closed;
  endproperty
  a_run_needs_bypass: assert property (p_run_needs_bypass)
    else $error("run without bypass closed");

  property p_ovp;
    @(posedge clk) disable iff (!arst_n)
      sample_tick && volt_q > `ARS_V_OVERVOLT |=> !ctl_q.conv_run && !ctl_q.bypass_closed;
  endproperty
  a_ovp: assert property (p_ovp)
    else $error("overvoltage not handled");

  property p_ov_state;
    @(posedge clk) disable iff (!arst_n)
      sample_tick && volt_q > `ARS_V_OVERVOLT && state_q != ARS_CHARGE
      |=> state_q == ARS_OVERVOLT && ctl_q.bus_good_n;
  endproperty
  a_ov_state: assert property (p_ov_state)
    else $error("overvoltage did not stop the sequence");

  property p_uvp;
    @(posedge clk) disable iff (!arst_n)
      sample_tick && volt_q < `ARS_V_UNDERVOLT |=> !ctl_q.bypass_closed;
  endproperty
  a_uvp: assert property (p_uvp)
    else $error("bypass left closed at undervoltage");

  property p_good_drop;
    @(posedge clk) disable iff (!arst_n)
      state_q == ARS_RUNNING && sample_tick && volt_q < `ARS_V_BUSGOOD_OFF
      && volt_q <= `ARS_V_OVERVOLT |=> ctl_q.bus_good_n;
  endproperty
  a_good_drop: assert property (p_good_drop)
    else $error("bus good not dropped");

  property p_run_drop;
    @(posedge clk) disable iff (!arst_n)
      state_q == ARS_DECAY && sample_tick && volt_q < `ARS_V_RUN_OFF
      |=> !ctl_q.conv_run && state_q == ARS_CHARGE;
  endproperty
  a_run_drop: assert property (p_run_drop)
    else $error("converters not disabled in decay");

  property p_decay_rerun;
    @(posedge clk) disable iff (!arst_n)
      state_q == ARS_DECAY && sample_tick && volt_q < `ARS_V_RUN_OFF
      |=> !ctl_q.doubler_on && !ctl_q.bypass_closed && ctl_q.bus_good_n;
  endproperty
  a_decay_rerun: assert property (p_decay_rerun)
    else $error("switches not back to initial state after disable");

  property p_no_restart;
    @(posedge clk) disable iff (!arst_n)
      state_q == ARS_DECAY && sample_tick && volt_q > `ARS_V_BYPASS
      && volt_q <= `ARS_V_OVERVOLT |=> state_q == ARS_RUNNING && !ctl_q.bus_good_n;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("power-up restarted on early recovery");

  property p_bypass_level;
    @(posedge clk) disable iff (!arst_n)
      $rose(ctl_q.bypass_closed) |-> $past(volt_q) > `ARS_V_BYPASS;
  endproperty
  a_bypass_level: assert property (p_bypass_level)
    else $error("bypass closed below threshold");

  property p_bypass_settled;
    @(posedge clk) disable iff (!arst_n)
      $rose(ctl_q.bypass_closed) |-> $past(settled) && $past(state_q) == ARS_CHARGE;
  endproperty
  a_bypass_settled: assert property (p_bypass_settled)
    else $error("bypass closed before the bus settled");

  property p_doubler_level;
    @(posedge clk) disable iff (!arst_n)
      $rose(ctl_q.doubler_on) |-> $past(volt_q) < `ARS_V_DOUBLER;
  endproperty
  a_doubler_level: assert property (p_doubler_level)
    else $error("doubler engaged above threshold");

  property p_doubler_settled;
    @(posedge clk) disable iff (!arst_n)
      $rose(ctl_q.doubler_on) |-> $past(settled);
  endproperty
  a_doubler_settled: assert property (p_doubler_settled)
    else $error("doubler engaged before the bus settled");
endmodule

// *** logic/ars_sync.sv ***
`timescale 1ns/100ps
module ars_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// *** verif/ars_bus_model.sv ***
`timescale 1ns/100ps
module ars_bus_model (
  // Clock
  input  wire logic       clk,
  // Supply level the bus charges or decays towards
  input  wire logic [9:0] target,
  // High collapses the bus to the target at once, as a fault or overload does
  input  wire logic       jump,
  // Measured bus voltage in whole volts
  output logic      [9:0] bus_volt
);
  // Bus slews one volt a cycle, like a capacitor charging or bleeding
  initial bus_volt = 10'h000;
  always @(posedge clk) begin
    if (jump) begin
      bus_volt <= target;
    end else if (bus_volt < target) begin
      bus_volt <= bus_volt + 10'h001;
    end else if (bus_volt > target) begin
      bus_volt <= bus_volt - 10'h001;
    end
  end
endmodule

// *** verif/ars_seq_tb.sv ***
`timescale 1ns/100ps
module ars_seq_tb;
  import ars_pkg::*;
  localparam int DLY = 10;
  logic       clk;
  logic       arst_n;
  logic [9:0] target;
  logic       jump;
  logic [9:0] bus_volt;
  ars_out_t   ctl;
  logic       sample_tick;
  int         n_mismatch;
  int         checks_done;
  int         cycles;
  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

  ars_bus_model u_ars_bus_model (
    .clk(clk), .target(target), .jump(jump), .bus_volt(bus_volt));
  ars_seq #(.SAMPLE_CYC(4), .DELAY_CYC(DLY), .SETTLE_CNT(4)) u_ars_seq (
    .clk(clk), .arst_n(arst_n), .bus_volt(bus_volt), .ctl(ctl), .sample_tick(sample_tick));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // Bounded wait for one control bit, sampled mid-cycle
  task automatic wait_bit(input int idx, input logic v, input string nm);
    int n;
    n = 0;
    while (ctl[idx] !== v && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK(nm, v, ctl[idx])
  endtask

  // Cycles from the previous event to this bit reaching v
  task automatic count_to(input int idx, input logic v, input string nm);
    int n;
    n = 0;
    while (ctl[idx] !== v && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK(nm, DLY, n)
  endtask

  task automatic set_bus(input logic [9:0] v);
    @(posedge clk);
    target <= v;
    jump   <= 1'b0;
  endtask

  task automatic t_reset_state;
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    `CHK("ctl in reset", 4'h1, ctl)
    @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    `CHK("ctl after reset", 4'h1, ctl)
    $display("test reset_state done");
  endtask

  task automatic t_power_up(input logic [9:0] v);
    set_bus(v);
    wait_bit(3, 1'b1, "bypass");
    `CHK("doubler high bus", 1'b0, ctl.doubler_on)
    `CHK("run before delay", 1'b0, ctl.conv_run)
    count_to(1, 1'b1, "run delay");
    count_to(0, 1'b0, "good delay");
    $display("test power_up done");
  endtask

  task automatic t_decay;
    set_bus(10'h0CB);
    wait_bit(0, 1'b1, "good off");
    `CHK("run at 203", 1'b1, ctl.conv_run)
    set_bus(10'h0F0);
    wait_bit(0, 1'b0, "good back");
    `CHK("no restart", 4'hA, ctl)
    set_bus(10'h0C3);
    wait_bit(1, 1'b0, "run off");
    $display("test decay done");
    t_power_up(10'h12C);
  endtask

  task automatic t_overvolt;
    set_bus(10'h1A4);
    wait_bit(1, 1'b0, "ov run");
    `CHK("ov bypass", 1'b0, ctl.bypass_closed)
    `CHK("ov good", 1'b1, ctl.bus_good_n)
    $display("test overvolt done");
    t_power_up(10'h12C);
  endtask

  // Bus collapses at once, so the bypass must open before the decay path disables the converters
  task automatic t_undervolt;
    @(posedge clk);
    target <= 10'h0AA;
    jump   <= 1'b1;
    wait_bit(3, 1'b0, "uv bypass");
    `CHK("uv run still on", 1'b1, ctl.conv_run)
    wait_bit(1, 1'b0, "uv run off");
    `CHK("uv run", 1'b0, ctl.conv_run)
    `CHK("uv bypass stays open", 1'b0, ctl.bypass_closed)
    $display("test undervolt done");
  endtask

  task automatic t_mid_band;
    set_bus(10'h0DC);
    repeat (200) @(negedge clk);
    `CHK("mid band", 4'h1, ctl)
    set_bus(10'h096);
    wait_bit(2, 1'b1, "doubler low bus");
    `CHK("bypass low bus", 1'b0, ctl.bypass_closed)
    $display("test mid_band done");
  endtask

  initial begin
    arst_n = 1'b0;
    target = 10'h000;
    jump = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_power_up(10'h12C);
    t_decay();
    t_overvolt();
    t_reset_state();
    wait_bit(0, 1'b0, "good after rerun");
    t_undervolt();
    t_mid_band();
    complete_run();
  end
endmodule
